// ---- dv/sdf_host_model.sv ----
`timescale 1ns/1ps
module sdf_host_model (
    // Control from the bench.
    input  wire logic        go,
    input  wire logic [15:0] wword,
    // Serial link.
    output logic             cs_n,
    output logic             sclk,
    output logic             din,
    input  wire logic        dout,
    // Captured frame.
    output logic [63:0]      frame,
    output logic             done
);
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
        frame = 64'h0;
        done = 1'b0;
    end

    // One 64-bit frame per go pulse; the link clock stands low between frames.
    // Data out is taken just before the next rise, after the device has moved it.
    always @(posedge go) begin
        done = 1'b0;
        #10;
        cs_n = 1'b0;
        #400;
        for (int i = 0; i < 64; i++) begin
            sclk = 1'b1;
            din = (i >= 48) ? wword[63 - i] : 1'b0;
            #200;
            sclk = 1'b0;
            #200;
            frame = {frame[62:0], dout};
        end
        #400;
        cs_n = 1'b1;
        din = 1'b0;
        done = 1'b1;
    end
endmodule

// ---- dv/sdf_top_bench.sv ----
`timescale 1ns/1ps
`include "sdf_map.svh"
module sdf_top_bench import sdf_pkg::*;;
    logic        clk_sys, rst, reg_wr, reg_rd, mod_sample, start_pin, osc_clk;
    logic        clock_source_select_pin, clk_pin_out, clk_pin_oe_n, clk_internal;
    logic        reference_buffer_power, reference_high_level_select;
    logic        cs_n, sclk, din, dout, dout_oe_n, data_ready_strobe_n;
    logic        go, done, rd_d;
    logic [3:0]  reg_addr, mod_bits;
    logic [1:0]  seen;
    sdf_word_t   reg_wdata, reg_rdata, wword;
    sdf_word_t   rd_q[$];
    logic [63:0] frame;
    logic [63:0] frm_q[$];
    int          n_mismatch, compares, seed, gap;
    realtime     t_clr;

    sdf_top sdf_top_i (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mod_bits(mod_bits), .mod_sample(mod_sample), .start_pin(start_pin),
        .clock_source_select_pin(clock_source_select_pin), .osc_clk(osc_clk),
        .clk_pin_out(clk_pin_out), .clk_pin_oe_n(clk_pin_oe_n), .clk_internal(clk_internal),
        .reference_buffer_power(reference_buffer_power),
        .reference_high_level_select(reference_high_level_select),
        .cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout), .dout_oe_n(dout_oe_n),
        .data_ready_strobe_n(data_ready_strobe_n));

    sdf_host_model sdf_host_model_i (.go(go), .wword(wword), .cs_n(cs_n), .sclk(sclk),
        .din(din), .dout(dout), .frame(frame), .done(done));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        osc_clk = 1'b0;
        // The oscillator input stands still while the block is held in reset.
        forever #85 osc_clk = rst ? 1'b0 : ~osc_clk;
    end

    task automatic report(input string what);
        n_mismatch++;
        $display("unexpected at %0t: %s", $time, what);
    endtask
    task automatic check_word(input sdf_word_t got, input sdf_word_t exp);
        compares++;
        if (got !== exp) report($sformatf("word %h, wanted %h", got, exp));
    endtask
    task automatic check_frame(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) report($sformatf("frame %h, wanted %h", got, exp));
    endtask
    task automatic check_flag(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) report(what);
    endtask
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [3:0] a, input sdf_word_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic reg_read(input logic [3:0] a, input sdf_word_t exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(exp);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Waits for the ready strobe and checks the time since t0 in clock cycles.
    task automatic wait_ready(input realtime t0, input int lo, input int hi);
        int n;
        n = 0;
        while (data_ready_strobe_n !== 1'b0 && n < 3000) begin
            @(posedge clk_sys);
            n++;
        end
        n = int'(($time - t0) / 50.0);
        check_flag(n >= lo && n <= hi, $sformatf("ready after %0d cycles", n));
        if (n > hi) complete_run();
    endtask

    // Reads one frame over the link; full also checks its content and the result registers.
    task automatic read_results(input bit full);
        int n;
        n = 0;
        wword <= 16'($random(seed));
        go <= 1'b1;
        if (full) frm_q.push_back({`SDF_OUT_POS, `SDF_OUT_NEG, 32'h0});
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (16) @(posedge clk_sys);
        check_flag(data_ready_strobe_n === 1'b1, "ready not cleared by link clock");
        while (done !== 1'b1 && n < 800) begin
            @(posedge clk_sys);
            n++;
        end
        if (n >= 800) begin
            report("frame never ended");
            complete_run();
        end
        repeat (8) @(posedge clk_sys);
        check_flag(dout_oe_n === 1'b1, "data out still driven");
        reg_read(`SDF_ADDR_HOSTW, wword);
        if (full) begin
            reg_read(`SDF_ADDR_RES0, `SDF_OUT_POS);
            reg_read(4'h5, `SDF_OUT_NEG);
            reg_read(4'h6, 16'h0000);
            reg_read(4'h7, 16'h0000);
        end
    endtask

    // Result watchers, plus the modulator feed: channels 2 and 3 alternate each sample.
    always @(posedge clk_sys) begin
        rd_d <= reg_rd;
        if (rd_d && rd_q.size() > 0) check_word(reg_rdata, rd_q.pop_front());
        gap <= rst ? -64 : (mod_sample ? 1 : gap + 1);
        if (mod_sample === 1'b1 && gap > 0) check_flag(gap == 8, "modulator rate");
        if (mod_sample === 1'b1) mod_bits[3:2] <= ~mod_bits[3:2];
    end
    always @(posedge done) begin
        if (frm_q.size() > 0) check_frame(frame, frm_q.pop_front());
    end

    initial begin
        seed = 32'h83DB;
        n_mismatch = 0;
        compares = 0;
        rst = 1'b1;
        {reg_addr, reg_wdata, reg_wr, reg_rd, start_pin, go, rd_d, gap} = '0;
        clock_source_select_pin = 1'b0;
        wword = 16'h0000;
        mod_bits = 4'h9;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        reg_read(`SDF_ADDR_CFG1, 16'(`SDF_CFG1_RST));
        reg_read(`SDF_ADDR_CFG2, 16'h0000);
        reg_read(`SDF_ADDR_CFG3, 16'h0000);
        reg_read(4'h9, 16'h0000);
        reg_read(`SDF_ADDR_STATUS, 16'h0001);
        check_flag(reference_buffer_power === 1'b0, "reference buffer on at wake");
        reg_write(`SDF_ADDR_CFG2, 16'h0001);
        reg_write(`SDF_ADDR_CFG3, 16'h0001);
        check_flag(reference_high_level_select === 1'b1, "high reference level");
        check_flag(reference_buffer_power === 1'b1, "reference buffer power");
        for (int k = 0; k < 4; k++) begin
            clock_source_select_pin <= k[1];
            reg_write(`SDF_ADDR_CFG1, {12'h000, k[0], 3'h6});
            seen = 2'b00;
            repeat (12) begin
                @(posedge clk_sys);
                seen = seen | (clk_pin_out ? 2'b10 : 2'b01);
            end
            check_flag(clk_pin_oe_n === ~(k[1] & k[0]), "clock pin drive");
            check_flag(clk_internal === k[1], "clock source");
            check_flag(seen == ((k == 3) ? 2'b11 : 2'b01), "clock pin level");
        end
        clock_source_select_pin <= 1'b0;
        reg_write(`SDF_ADDR_CFG1, 16'h0006);
        start_pin <= 1'b1;
        wait_ready($time, 3 * 8 * 32, 4 * 8 * 32 + 40);
        read_results(1'b1);
        t_clr = $time;
        reg_write(`SDF_ADDR_CFG1, 16'h0005);
        read_results(1'b0);
        wait_ready(t_clr, 3 * 8 * 64, 4 * 8 * 64 + 40);
        read_results(1'b1);
        complete_run();
    end
endmodule

// ---- verilog/sdf_map.svh ----
`ifndef SDF_MAP_SVH
`define SDF_MAP_SVH

// Register indices on the plain register port.
`define SDF_ADDR_CFG1      4'h0
`define SDF_ADDR_CFG2      4'h1
`define SDF_ADDR_CFG3      4'h2
`define SDF_ADDR_STATUS    4'h3
`define SDF_ADDR_RES0      4'h4
`define SDF_ADDR_HOSTW     4'h8

// Field positions and reset values.
`define SDF_DR_MSB         2
`define SDF_DR_LSB         0
`define SDF_CLKOUT_BIT     3
`define SDF_CFG1_RST       4'h6
`define SDF_REFHI_RST      1'b0
`define SDF_REFBUF_RST     1'b0

// Filter shape and timing counts.
`define SDF_NUM_CH         4
`define SDF_WORD_W         16
`define SDF_ACC_W          36
`define SDF_FRAME_W        64
`define SDF_LOG2N_MAX      4'hB
`define SDF_DR_MAX         3'h6
`define SDF_MOD_DIV_LAST   3'h7
`define SDF_SETTLE_DUMPS   2'h3
`define SDF_SHIFT_BASE     6'h0F
`define SDF_ORDER          6'h03
`define SDF_OUT_POS        16'h7FFF
`define SDF_OUT_NEG        16'h8000
`define SDF_SYNC_W         6

`endif

// ---- verilog/sdf_pkg.sv ----
package sdf_pkg;
    typedef logic signed [35:0] sdf_acc_t;
    typedef logic [15:0]        sdf_word_t;
    typedef enum logic [2:0] {
        SDF_IDLE   = 3'h1,
        SDF_SETTLE = 3'h2,
        SDF_RUN    = 3'h4
    } sdf_state_t;
endpackage

// ---- verilog/sdf_sinc3.sv ----
`timescale 1ns/1ps
`include "sdf_map.svh"
module sdf_sinc3 import sdf_pkg::*; (
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Control.
    input  wire logic       clear,
    input  wire logic       sample_en,
    input  wire logic       dump,
    input  wire logic [4:0] shift,
    // Bitstream in.
    input  wire logic       bit_in,
    // Result out.
    output sdf_word_t       word,
    output logic            word_valid
);
    sdf_acc_t integ1_r, integ2_r, integ3_r;
    sdf_acc_t dly1_r, dly2_r, dly3_r;
    sdf_acc_t step;
    sdf_acc_t comb1, comb2, comb3, scaled;

    // A one bit counts as plus one, a zero as minus one.
    assign step = bit_in ? 36'sh000000001 : -36'sh000000001;

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin // [R19]
            integ1_r <= '0;
            integ2_r <= '0;
            integ3_r <= '0;
        end else if (sample_en) begin // [R2]
            integ1_r <= integ1_r + step; // [R3]
            integ2_r <= integ2_r + integ1_r;
            integ3_r <= integ3_r + integ2_r;
        end
    end

    always_comb begin
        comb1  = integ3_r - dly1_r; // [R3]
        comb2  = comb1 - dly2_r;
        comb3  = comb2 - dly3_r;
        scaled = comb3 >>> shift; // [R20]
    end

    always_ff @(posedge clk_sys) begin
        if (rst || clear) begin // [R19]
            dly1_r     <= '0;
            dly2_r     <= '0;
            dly3_r     <= '0;
            word       <= '0;
            word_valid <= 1'b0;
        end else begin
            word_valid <= dump; // [R2]
            if (dump) begin
                dly1_r <= integ3_r;
                dly2_r <= comb1;
                dly3_r <= comb2;
                if (scaled > 36'sh000007FFF) begin
                    word <= `SDF_OUT_POS; // [R8]
                end else if (scaled < -36'sh000008000) begin
                    word <= `SDF_OUT_NEG; // [R8]
                end else begin
                    word <= scaled[15:0]; // [R7] [R9]
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst || clear);

    sat_high_a: assert property (dump && scaled > 36'sh000007FFF |=> word == 16'h7FFF) // [R8]
        else $error("positive overrange not clipped");
    sat_low_a: assert property (dump && scaled < -36'sh000008000 |=> word == 16'h8000) // [R8]
        else $error("negative overrange not clipped");
    sat_cov_c: cover property (dump && scaled > 36'sh000007FFF);
endmodule

// ---- verilog/sdf_top.sv ----
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "sdf_map.svh"
// Overview of operation
// R1: Every channel runs a third-order sinc low-pass with programmable decimation.
// R2: One modulator bit taken per modulator period; decimation ratio sets output rate.
// R3: Response is ((1 - z^-N)/(1 - z^-1)) cubed: three integrators, three combs.
// R4: Notches fall at the output rate and its integer multiples.
// R5: After a step, three output periods settle; fourth ready strobe is settled.
// R6: After conversion start rises, first output waits a rate-dependent settle interval.
// R7: Each channel result is a 16-bit twos-complement word sent MSB first.
// R8: Results clip to 7FFFh at positive and 8000h at negative full scale.
// R9: One step is Vref/(2^15-1); zero gives 0000h, plus one 0001h, minus one FFFFh.
// R10: Source select low: external clock, clock pin is input whatever the enable.
// R11: Source select high: internal oscillator; pin floats or drives per enable bit.
// R12: Host should stop an external clock during power-down to save power.
// R13: Wakes in external reference mode; buffer power bit switches reference buffer.
// R14: Internal reference 2.4V unless high-level bit set; 4V only with 5V supply.
// R15: Host uses four-wire serial link to read results and control the device; here din only fills host_word_r, control is by the register port.
// R16: Data-ready strobe goes low each time a new result set is available.
// R17: Modulator samples at one eighth of the master clock.
// R18: One data-rate field in the first configuration register sets all channels.
// R19: Reset or ratio change clears filter state and restarts settle counting.
// R20: Full-precision accumulator is scaled to 16 bits and saturated.
module sdf_top import sdf_pkg::*; (
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Register port.
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    // Modulator side.
    input  wire logic [3:0]  mod_bits,
    output logic             mod_sample,
    // Conversion start pin.
    input  wire logic        start_pin,
    // Clock selection.
    input  wire logic        clock_source_select_pin,
    input  wire logic        osc_clk,
    output logic             clk_pin_out,
    output logic             clk_pin_oe_n,
    output logic             clk_internal,
    // Reference control.
    output logic             reference_buffer_power,
    output logic             reference_high_level_select,
    // Serial link.
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        din,
    output logic             dout,
    output logic             dout_oe_n,
    output logic             data_ready_strobe_n
);
    localparam int NCH = `SDF_NUM_CH;

    logic [5:0]       sync1_r, sync2_r, sync3_r;
    logic             start_s, clock_source_select_pin_s, osc_s, cs_s, sclk_s, din_s;
    logic             start_rise, cs_fall, sclk_rise, sclk_fall;
    logic [3:0]       cfg1_r;
    logic [2:0]       dr_eff;
    logic [3:0]       log2n;
    logic [5:0]       shift_full;
    logic [10:0]      n_m1;
    logic [2:0]       mod_cnt_r;
    logic [10:0]      dec_cnt_r;
    logic             dump_r;
    logic             clear_r;
    sdf_state_t       state_r;
    logic [1:0]       settle_cnt_r;
    sdf_word_t        ch_word [NCH];
    logic [NCH-1:0]   ch_valid;
    logic             present;
    logic             new_set_r;
    sdf_word_t        result_r [NCH];
    logic [63:0]      frame_r;
    logic [15:0]      host_word_r;

    // Pins from outside pass two flip-flops; the third only feeds edge detection.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= 6'h08;
            sync2_r <= 6'h08;
            sync3_r <= 6'h08;
        end else begin
            sync1_r <= {din, sclk, cs_n, osc_clk, clock_source_select_pin, start_pin};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    assign start_s    = sync2_r[0];
    assign clock_source_select_pin_s   = sync2_r[1];
    assign osc_s      = sync2_r[2];
    assign cs_s       = sync2_r[3];
    assign sclk_s     = sync2_r[4];
    assign din_s      = sync2_r[5];
    assign start_rise = start_s && !sync3_r[0];
    assign cs_fall    = !cs_s && sync3_r[3];
    assign sclk_rise  = sclk_s && !sync3_r[4] && !cs_s;
    assign sclk_fall  = !sclk_s && sync3_r[4] && !cs_s;

    // Decimation ratio N = 2^log2n, from 2048 down to 32; codes above six clamp.
    assign dr_eff     = (cfg1_r[`SDF_DR_MSB:`SDF_DR_LSB] > `SDF_DR_MAX) ?
                        `SDF_DR_MAX : cfg1_r[`SDF_DR_MSB:`SDF_DR_LSB]; // [R18]
    assign log2n      = `SDF_LOG2N_MAX - {1'b0, dr_eff};
    assign shift_full = {2'b00, log2n} * `SDF_ORDER - `SDF_SHIFT_BASE; // [R20]
    assign n_m1       = 11'((12'h001 << log2n) - 12'h001);

    // Configuration registers.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg1_r                      <= `SDF_CFG1_RST;
            reference_high_level_select <= `SDF_REFHI_RST; // [R14]
            reference_buffer_power      <= `SDF_REFBUF_RST; // [R13]
        end else if (reg_wr) begin
            if (reg_addr == `SDF_ADDR_CFG1) begin
                cfg1_r <= reg_wdata[3:0]; // [R18]
            end else if (reg_addr == `SDF_ADDR_CFG2) begin
                reference_high_level_select <= reg_wdata[0]; // [R14]
            end else if (reg_addr == `SDF_ADDR_CFG3) begin
                reference_buffer_power <= reg_wdata[0]; // [R13]
            end
        end
    end

    // A new ratio or a fresh start clears the filters.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clear_r <= 1'b1;
        end else begin
            clear_r <= start_rise || (reg_wr && reg_addr == `SDF_ADDR_CFG1 &&
                       reg_wdata[2:0] != cfg1_r[2:0]); // [R19] [R6]
        end
    end

    // Modulator rate is the master clock divided by eight.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            mod_cnt_r  <= '0;
            mod_sample <= 1'b0;
        end else begin
            mod_cnt_r  <= mod_cnt_r + 3'h1;
            mod_sample <= (mod_cnt_r == `SDF_MOD_DIV_LAST); // [R17]
        end
    end

    // Decimation counter: one dump every N modulator samples.
    always_ff @(posedge clk_sys) begin
        if (rst || clear_r || state_r == SDF_IDLE) begin
            dec_cnt_r <= '0;
            dump_r    <= 1'b0;
        end else begin
            dump_r <= mod_sample && (dec_cnt_r == n_m1); // [R2] [R4]
            if (mod_sample) begin
                dec_cnt_r <= (dec_cnt_r == n_m1) ? 11'h000 : dec_cnt_r + 11'h001;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            sdf_sinc3 u_sinc (
                .clk_sys    (clk_sys),
                .rst        (rst),
                .clear      (clear_r || state_r == SDF_IDLE),
                .sample_en  (mod_sample && state_r != SDF_IDLE),
                .dump       (dump_r),
                .shift      (shift_full[4:0]),
                .bit_in     (mod_bits[g]),
                .word       (ch_word[g]),
                .word_valid (ch_valid[g])
            ); // [R1]
        end
    endgenerate

    // Conversion sequencing: the first three dumps after a clear are discarded.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_r      <= SDF_IDLE;
            settle_cnt_r <= '0;
        end else if (!start_s) begin
            state_r      <= SDF_IDLE;
            settle_cnt_r <= '0;
        end else if (clear_r) begin
            state_r      <= SDF_SETTLE; // [R19] [R6]
            settle_cnt_r <= '0;
        end else begin
            case (state_r)
                SDF_IDLE: begin
                    state_r      <= SDF_SETTLE;
                    settle_cnt_r <= '0;
                end
                SDF_SETTLE: begin
                    if (ch_valid[0]) begin
                        settle_cnt_r <= settle_cnt_r + 2'h1;
                        if (settle_cnt_r == `SDF_SETTLE_DUMPS) begin
                            state_r <= SDF_RUN; // [R5]
                        end
                    end
                end
                SDF_RUN: state_r <= SDF_RUN;
                default: state_r <= SDF_IDLE;
            endcase
        end
    end

    assign present = ch_valid[0] && !clear_r && start_s && (state_r == SDF_RUN ||
                     (state_r == SDF_SETTLE && settle_cnt_r == `SDF_SETTLE_DUMPS));

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            new_set_r <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                result_r[i] <= '0;
            end
        end else begin
            new_set_r <= present;
            if (present) begin
                for (int i = 0; i < NCH; i++) begin
                    result_r[i] <= ch_word[i]; // [R5]
                end
            end
        end
    end

    // Ready strobe: a new set wins over the clearing serial clock edge.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            data_ready_strobe_n <= 1'b1;
        end else if (present) begin
            data_ready_strobe_n <= 1'b0; // [R16]
        end else if (sclk_rise) begin
            data_ready_strobe_n <= 1'b1;
        end
    end

    // Serial frame: channel words MSB first; output shifts on rising serial clock.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            frame_r     <= '0;
            dout        <= 1'b0;
            dout_oe_n   <= 1'b1;
            host_word_r <= '0;
        end else begin
            dout_oe_n <= cs_s; // [R15]
            if (cs_fall) begin
                frame_r <= {result_r[0], result_r[1], result_r[2], result_r[3]};
            end else if (sclk_rise) begin
                dout    <= frame_r[63]; // [R7] [R15]
                frame_r <= {frame_r[62:0], frame_r[63]};
            end
            if (sclk_fall) begin
                host_word_r <= {host_word_r[14:0], din_s}; // [R15]
            end
        end
    end

    // Clock pin control.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            clk_internal <= 1'b0;
            clk_pin_oe_n <= 1'b1;
            clk_pin_out  <= 1'b0;
        end else begin
            clk_internal <= clock_source_select_pin_s; // [R10] [R11]
            clk_pin_oe_n <= !(clock_source_select_pin_s && cfg1_r[`SDF_CLKOUT_BIT]); // [R10] [R11]
            clk_pin_out  <= clock_source_select_pin_s && cfg1_r[`SDF_CLKOUT_BIT] && osc_s; // [R11]
        end
    end

    // Register read data stand in the cycle after the read strobe.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            if (reg_addr == `SDF_ADDR_CFG1) begin
                reg_rdata <= {12'h000, cfg1_r};
            end else if (reg_addr == `SDF_ADDR_CFG2) begin
                reg_rdata <= {15'h0000, reference_high_level_select};
            end else if (reg_addr == `SDF_ADDR_CFG3) begin
                reg_rdata <= {15'h0000, reference_buffer_power};
            end else if (reg_addr == `SDF_ADDR_STATUS) begin
                reg_rdata <= {10'h000, !data_ready_strobe_n, settle_cnt_r, state_r};
            end else if (reg_addr >= `SDF_ADDR_RES0 && reg_addr < `SDF_ADDR_HOSTW) begin
                reg_rdata <= result_r[reg_addr[1:0]];
            end else if (reg_addr == `SDF_ADDR_HOSTW) begin
                reg_rdata <= host_word_r;
            end else begin
                reg_rdata <= '0;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    mod_rate_a: assert property (mod_sample |=> !mod_sample [*7] ##1 mod_sample) // [R17]
        else $error("modulator strobe not one in eight cycles");
    settle_skip_a: assert property (ch_valid[0] && state_r == SDF_SETTLE && // [R5]
        settle_cnt_r != 2'h3 |=> !new_set_r)
        else $error("unsettled result presented");
    settle_four_a: assert property (ch_valid[0] && state_r == SDF_SETTLE && start_s && // [R5]
        !clear_r && settle_cnt_r == 2'h3 |=> new_set_r && state_r == SDF_RUN)
        else $error("fourth result not presented");
    ready_low_a: assert property (new_set_r |-> !data_ready_strobe_n) // [R16]
        else $error("ready strobe missing on new set");
    clk_ext_a: assert property (!clock_source_select_pin_s |=> clk_pin_oe_n && !clk_internal) // [R10]
        else $error("clock pin driven in external mode");
    clk_int_a: assert property (clock_source_select_pin_s && cfg1_r[3] |=> !clk_pin_oe_n && clk_internal) // [R11]
        else $error("oscillator not driven out");
    ref_wake_a: assert property ($fell(rst) |-> !reference_buffer_power // [R13] [R14]
        && !reference_high_level_select)
        else $error("reference not in external low mode at wake");
    dout_hiz_a: assert property (cs_s |=> dout_oe_n) // [R15]
        else $error("serial output driven while deselected");
    ratio_clear_a: assert property (clear_r && start_s |=> state_r == SDF_SETTLE // [R19]
        && settle_cnt_r == 2'h0)
        else $error("settle not restarted after clear");

    run_cov_c: cover property (state_r == SDF_SETTLE ##[1:1000] state_r == SDF_RUN);
    read_cov_c: cover property (cs_fall ##[1:1000] sclk_rise);
    clkout_cov_c: cover property (clock_source_select_pin_s && !clk_pin_oe_n);
endmodule
